// *** design/dbgwr_core.sv ***
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
// debug enclave write: request check, page-map lookup, store
module dbgwr_core import dbgwr_pkg::*; (
  input wire logic mclk_in,
  input wire logic rstn_in,
  // request from the leaf dispatcher
  input wire logic req_in,
  input wire logic [31:0] leaf_in,
  input wire logic [63:0] target_address_reg_in,
  input wire logic [63:0] write_data_reg_in,
  input wire logic long_mode_active_in,
  input wire logic cs_long_in,
  input wire logic [1:0] current_privilege_level_in,
  input wire logic ds_usable_in,
  input wire logic ds_writable_in,
  input wire logic [31:0] ds_limit_in,
  input wire logic [31:0] arith_flags_in,
  output logic busy_out,
  output logic done_out,
  output logic general_protection_fault_out,
  output logic page_fault_exception_out,
  output logic [63:0] fault_code_out,
  output logic [31:0] arith_flags_out,
  // page-map lookup
  output logic map_req_out,
  output logic [63:0] map_addr_out,
  input wire logic map_ack_in,
  input wire logic map_in_epc_in,
  input wire logic map_busy_in,
  input wire logic map_valid_in,
  input wire logic [7:0] map_type_in,
  input wire logic map_debug_in,
  // store into the page cache
  output logic mem_wr_out,
  output logic [63:0] mem_addr_out,
  output logic [63:0] mem_data_out,
  output logic [7:0] mem_be_out,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out
);
  dbgwr_state_e state_r, state_nxt;
  logic [63:0] addr_r;
  logic [63:0] data_r;
  logic wide_r;
  logic [31:0] flags_r;
  logic [31:0] ctrl_r;
  logic done_r, gp_r, pf_r, leaf_ev_r, map_req_r, mem_wr_r;
  logic [63:0] code_r;
  logic [7:0] be_r;
  logic [31:0] rdata_r;
  logic busy_r;
  logic [EV_W-1:0] status_w, mask_w;
  logic pre_gp;

  // ------------------------------------------------------------
  // request acceptance and operand checks
  // ------------------------------------------------------------
  wire logic wide_w = long_mode_active_in && cs_long_in;
  wire logic take = (state_r == ST_IDLE) && req_in && ctrl_r[CTRL_EN];
  wire logic leaf_ok = (leaf_in == LEAF_DBG_WRITE);
  wire logic start = take && leaf_ok;
  wire logic bad_leaf = take && !leaf_ok;

  dbgwr_precheck u_pre (
    .addr_in(target_address_reg_in),
    .wide_in(wide_w),
    .cpl_in(current_privilege_level_in),
    .ds_usable_in(ds_usable_in),
    .ds_writable_in(ds_writable_in),
    .ds_limit_in(ds_limit_in),
    .gp_out(pre_gp)
  );

  // ------------------------------------------------------------
  // page-map answer, in the documented priority
  // ------------------------------------------------------------
  // permission bits of the entry are deliberately not looked at
  wire logic look = (state_r == ST_LOOKUP) && map_ack_in;
  wire logic is_reg = (map_type_in == REGULAR_PAGE_TYPE);
  wire logic is_tcs = (map_type_in == THREAD_PAGE_TYPE);
  wire logic f_epc = !map_in_epc_in;
  wire logic f_busy = !f_epc && map_busy_in;
  wire logic f_valid = !f_epc && !map_busy_in && !map_valid_in;
  wire logic ent_ok = map_in_epc_in && !map_busy_in && map_valid_in;
  // control-structure pages and any other type fall here
  wire logic f_type = ent_ok && !is_reg && !is_tcs;
  wire logic tcs_off_bad = (addr_r[11:0] & TCS_OFF_MASK) != (TCS_FLAGS_OFF & TCS_OFF_MASK);
  wire logic f_tcs = ent_ok && is_tcs && tcs_off_bad;
  wire logic f_dbg = ent_ok && (is_reg || is_tcs) && !f_tcs && !map_debug_in;
  wire logic look_pf = f_epc || f_valid || f_type;
  wire logic look_gp = f_busy || f_tcs || f_dbg;
  wire logic look_ok = !look_pf && !look_gp;

  // ------------------------------------------------------------
  // completion terms
  // ------------------------------------------------------------
  wire logic fin_gp = (start && pre_gp) || (look && look_gp);
  wire logic fin_pf = look && look_pf;
  wire logic fin = fin_gp || fin_pf || (state_r == ST_WRITE);
  wire logic [63:0] code_nxt = fin_pf ? addr_r : GP_ERR_CODE;
  wire logic [7:0] be_nxt = wide_r ? BE_WIDE : BE_NARROW;

  // next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start && !pre_gp) begin
          state_nxt = ST_LOOKUP;
        end
      end
      ST_LOOKUP: begin
        if (look) begin
          state_nxt = look_ok ? ST_WRITE : ST_IDLE;
        end
      end
      ST_WRITE: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // operand capture; flags come back untouched
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr_r <= '0;
      data_r <= '0;
      wide_r <= 1'b0;
      flags_r <= '0;
    end else if (start) begin
      addr_r <= target_address_reg_in;
      data_r <= write_data_reg_in;
      wide_r <= wide_w;
      flags_r <= arith_flags_in;
    end
  end

  // state and response strobes
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= ST_IDLE;
      done_r <= 1'b0;
      gp_r <= 1'b0;
      pf_r <= 1'b0;
      leaf_ev_r <= 1'b0;
      code_r <= '0;
    end else begin
      state_r <= state_nxt;
      done_r <= fin;
      gp_r <= fin_gp;
      pf_r <= fin_pf;
      leaf_ev_r <= bad_leaf;
      if (fin) begin
        code_r <= code_nxt;
      end
    end
  end

  // lookup request level and single-cycle store; narrow writes use the low lanes
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      map_req_r <= 1'b0;
      mem_wr_r <= 1'b0;
      busy_r <= 1'b0;
      be_r <= '0;
    end else begin
      map_req_r <= (state_nxt == ST_LOOKUP);
      mem_wr_r <= look && look_ok;
      // busy from its own flop so the pin carries no gate after the register
      busy_r <= (state_nxt == ST_LOOKUP) || (look && look_ok);
      be_r <= be_nxt;
    end
  end

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  wire logic ctrl_wr = reg_wr_in && reg_addr_in == REG_CTRL;
  wire logic [31:0] state_word = {29'h0, wide_r, map_req_r, state_r != ST_IDLE};
  wire logic [31:0] rd_mux =
    (reg_addr_in == REG_STATUS) ? {{(32-EV_W){1'b0}}, status_w} :
    (reg_addr_in == REG_MASK) ? {{(32-EV_W){1'b0}}, mask_w} :
    (reg_addr_in == REG_CTRL) ? ctrl_r :
    (reg_addr_in == REG_CODE_LO) ? code_r[31:0] :
    (reg_addr_in == REG_CODE_HI) ? code_r[63:32] :
    (reg_addr_in == REG_STATE) ? state_word : 32'h0;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_r <= CTRL_RST;
      rdata_r <= '0;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= {31'h0, reg_wdata_in[CTRL_EN]};
      end
      rdata_r <= reg_rd_in ? rd_mux : 32'h0;
    end
  end

  dbgwr_irq u_irq (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .ev_in({leaf_ev_r, pf_r, gp_r, done_r}),
    .wr_in(reg_wr_in),
    .addr_in(reg_addr_in),
    .wdata_in(reg_wdata_in),
    .status_out(status_w),
    .mask_out(mask_w),
    .irq_out(irq_out)
  );

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign busy_out = busy_r;
  assign done_out = done_r;
  assign general_protection_fault_out = gp_r;
  assign page_fault_exception_out = pf_r;
  assign fault_code_out = code_r;
  assign arith_flags_out = flags_r;
  assign map_req_out = map_req_r;
  assign map_addr_out = addr_r;
  assign mem_wr_out = mem_wr_r;
  assign mem_addr_out = addr_r;
  assign mem_data_out = data_r;
  assign mem_be_out = be_r;
  assign reg_rdata_out = rdata_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  a_leaf_decode: assert property (bad_leaf |=> !map_req_r && !done_r)
    else $error("other leaf started an operation");
  a_store_size: assert property (mem_wr_r |-> mem_be_out == (wide_r ? BE_WIDE : BE_NARROW))
    else $error("store size does not follow mode");
  a_wide_mode: assert property (start |=> wide_r == $past(long_mode_active_in && cs_long_in))
    else $error("wide mode latched wrongly");
  a_align_gp: assert property (start && wide_w && target_address_reg_in[2:0] != 3'h0
    |=> done_r && gp_r && code_r == GP_ERR_CODE)
    else $error("misaligned target not faulted");
  a_epc_pf: assert property (look && f_epc |=> pf_r && !gp_r && code_r == $past(addr_r))
    else $error("non-cache page not page faulted");
  a_busy_gp: assert property (look && f_busy |=> gp_r && !pf_r)
    else $error("concurrent modifier not faulted");
  a_invalid_pf: assert property (look && f_valid |=> pf_r && code_r == $past(addr_r))
    else $error("invalid entry not page faulted");
  a_type_pf: assert property (look && f_type |=> pf_r && !mem_wr_r)
    else $error("wrong page type written");
  a_tcs_flags: assert property (look && ent_ok && is_tcs && tcs_off_bad |=> gp_r && !mem_wr_r)
    else $error("thread page written off its flags word");
  a_debug_gp: assert property (look && ent_ok && is_reg && !map_debug_in |=> gp_r)
    else $error("non-debug enclave written");
  a_ok_write: assert property (look && look_ok |=> mem_wr_r ##1 done_r && !gp_r && !pf_r)
    else $error("clean lookup did not store");
  a_cpl_gp: assert property (start && current_privilege_level_in != CPL_KERNEL
    |=> gp_r && state_r == ST_IDLE)
    else $error("nonzero privilege not faulted");
  a_flags_kept: assert property (start |=> arith_flags_out == $past(arith_flags_in))
    else $error("flags changed");
  a_seg_gp: assert property (start && !ds_usable_in |=> gp_r)
    else $error("unusable segment not faulted");
  a_canon_gp: assert property (start && wide_w && (target_address_reg_in[63]
    != target_address_reg_in[VA_BITS-1]) |=> gp_r)
    else $error("non-canonical target not faulted");

  c_store: cover property (look && look_ok ##1 mem_wr_r ##1 done_r);
  c_tcs_ok: cover property (look && is_tcs && look_ok);
  c_page_fault: cover property (pf_r && irq_out);
endmodule // dbgwr_core

// *** design/dbgwr_pkg.sv ***
package dbgwr_pkg;
  // ------------------------------------------------------------
  // request decode and operand checks
  // ------------------------------------------------------------
  localparam logic [31:0] LEAF_DBG_WRITE = 32'h0000_0005;
  localparam logic [2:0] ALIGN_WIDE_MASK = 3'h7;
  localparam logic [2:0] ALIGN_NARROW_MASK = 3'h3;
  localparam logic [2:0] SIZE_WIDE_M1 = 3'h7;
  localparam logic [2:0] SIZE_NARROW_M1 = 3'h3;
  localparam int VA_BITS = 48;
  localparam logic [1:0] CPL_KERNEL = 2'h0;
  localparam logic [7:0] BE_WIDE = 8'hff;
  localparam logic [7:0] BE_NARROW = 8'h0f;
  localparam logic [63:0] GP_ERR_CODE = 64'h0;
  // ------------------------------------------------------------
  // page-map entry encodings
  // ------------------------------------------------------------
  localparam logic [7:0] REGULAR_PAGE_TYPE = 8'h01;
  localparam logic [7:0] THREAD_PAGE_TYPE = 8'h02;
  localparam logic [11:0] TCS_OFF_MASK = 12'hff8;
  localparam logic [11:0] TCS_FLAGS_OFF = 12'h008;
  // ------------------------------------------------------------
  // register map and event bits
  // ------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_CODE_LO = 8'h0c;
  localparam logic [7:0] REG_CODE_HI = 8'h10;
  localparam logic [7:0] REG_STATE = 8'h14;
  localparam int EV_W = 4;
  localparam int EV_DONE = 0;
  localparam int EV_GP = 1;
  localparam int EV_PF = 2;
  localparam int EV_LEAF = 3;
  localparam int CTRL_EN = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  typedef enum logic [1:0] {ST_IDLE, ST_LOOKUP, ST_WRITE} dbgwr_state_e;
endpackage

// *** design/dbgwr_precheck.sv ***
`timescale 1ns/10ps
// operand checks that need no page-map lookup
module dbgwr_precheck import dbgwr_pkg::*; (
  input wire logic [63:0] addr_in,
  input wire logic wide_in,
  input wire logic [1:0] cpl_in,
  input wire logic ds_usable_in,
  input wire logic ds_writable_in,
  input wire logic [31:0] ds_limit_in,
  output logic gp_out
);
  // ------------------------------------------------------------
  // individual fault terms
  // ------------------------------------------------------------
  wire logic [63:VA_BITS-1] hi_bits = addr_in[63:VA_BITS-1];
  wire logic [2:0] size_m1 = wide_in ? SIZE_WIDE_M1 : SIZE_NARROW_M1;
  wire logic [2:0] amask = wide_in ? ALIGN_WIDE_MASK : ALIGN_NARROW_MASK;
  wire logic [32:0] last_byte = {1'b0, addr_in[31:0]} + {30'h0, size_m1};
  wire logic cpl_bad = (cpl_in != CPL_KERNEL);
  // limit and rights are only meaningful outside wide mode
  wire logic seg_bad = !ds_usable_in ||
    (!wide_in && (!ds_writable_in || last_byte > {1'b0, ds_limit_in}));
  wire logic canon_bad = wide_in && !((&hi_bits) || !(|hi_bits));
  wire logic align_bad = |(addr_in[2:0] & amask);
  assign gp_out = cpl_bad | seg_bad | canon_bad | align_bad;
endmodule // dbgwr_precheck

// *** design/dbgwr_irq.sv ***
`timescale 1ns/10ps
// sticky event status, mask and level interrupt
module dbgwr_irq import dbgwr_pkg::*; (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [EV_W-1:0] ev_in,
  input wire logic wr_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  output logic [EV_W-1:0] status_out,
  output logic [EV_W-1:0] mask_out,
  output logic irq_out
);
  logic [EV_W-1:0] status_r;
  logic [EV_W-1:0] mask_r;
  logic irq_r;
  wire logic [EV_W-1:0] clr = (wr_in && addr_in == REG_STATUS) ? wdata_in[EV_W-1:0] : '0;
  // set wins over a write-one clear in the same cycle
  wire logic [EV_W-1:0] status_nxt = (status_r & ~clr) | ev_in;
  wire logic [EV_W-1:0] mask_nxt = (wr_in && addr_in == REG_MASK) ? wdata_in[EV_W-1:0] : mask_r;
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= |(status_nxt & mask_nxt);
    end
  end
  assign status_out = status_r;
  assign mask_out = mask_r;
  assign irq_out = irq_r;
endmodule // dbgwr_irq

// *** verif/test_debug_enclave_write_check.sv ***
`timescale 1ns/10ps
module test_debug_enclave_write_check import dbgwr_pkg::*;;
  // ------------------------------------------------------------
  // stimulus and design hookup
  // ------------------------------------------------------------
  logic mclk_in = 1'b0, rstn_in = 1'b0, req_in = 1'b0, map_ack_in = 1'b0;
  logic long_mode_active_in = 1'b0, cs_long_in = 1'b0;
  logic ds_usable_in = 1'b1, ds_writable_in = 1'b1, map_in_epc_in = 1'b0;
  logic map_busy_in = 1'b0, map_valid_in = 1'b0, map_debug_in = 1'b0;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [1:0] current_privilege_level_in = 2'h0;
  logic [7:0] map_type_in = 8'h00, reg_addr_in = 8'h00, mem_be_out;
  logic [31:0] leaf_in = 32'h0, ds_limit_in = 32'h0, arith_flags_in = 32'h0;
  logic [31:0] reg_wdata_in = 32'h0, arith_flags_out, reg_rdata_out;
  logic [63:0] target_address_reg_in = 64'h0, write_data_reg_in = 64'h0;
  logic [63:0] fault_code_out, map_addr_out, mem_addr_out, mem_data_out;
  logic busy_out, done_out, general_protection_fault_out, page_fault_exception_out;
  logic map_req_out, mem_wr_out, irq_out;
  // operand set used by the next request, changed only between requests
  logic [31:0] g_leaf = LEAF_DBG_WRITE, g_lim = 32'hffff_ffff;
  logic [63:0] g_data = 64'h1122_3344_5566_7788;
  logic [1:0] g_cpl = 2'h0, g_ds = 2'h3;
  logic [3:0] g_map = 4'b1011; // in cache, not busy, valid, debug
  logic [7:0] g_type = REGULAR_PAGE_TYPE;
  int g_dly = 0, miscompares = 0, checks = 0;

  dbgwr_core dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .req_in(req_in), .leaf_in(leaf_in),
    .target_address_reg_in(target_address_reg_in), .write_data_reg_in(write_data_reg_in),
    .long_mode_active_in(long_mode_active_in), .cs_long_in(cs_long_in),
    .current_privilege_level_in(current_privilege_level_in), .ds_usable_in(ds_usable_in),
    .ds_writable_in(ds_writable_in), .ds_limit_in(ds_limit_in),
    .arith_flags_in(arith_flags_in), .busy_out(busy_out), .done_out(done_out),
    .general_protection_fault_out(general_protection_fault_out),
    .page_fault_exception_out(page_fault_exception_out), .fault_code_out(fault_code_out),
    .arith_flags_out(arith_flags_out), .map_req_out(map_req_out), .map_addr_out(map_addr_out),
    .map_ack_in(map_ack_in), .map_in_epc_in(map_in_epc_in), .map_busy_in(map_busy_in),
    .map_valid_in(map_valid_in), .map_type_in(map_type_in), .map_debug_in(map_debug_in),
    .mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out), .mem_data_out(mem_data_out),
    .mem_be_out(mem_be_out), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .irq_out(irq_out));

  // 50 MHz clock
  always #10 mclk_in = ~mclk_in;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (miscompares == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_wr_in <= 1'b1; reg_addr_in <= a; reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask

  // read data is only valid in the cycle right after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk_in);
    reg_rd_in <= 1'b1; reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    @(negedge mclk_in);
    chk(reg_rdata_out, exp);
  endtask

  // one request; md = {long mode, code long}; ex 0 ok, 1 gp, 2 pf, 3 no completion
  task automatic op(input logic [63:0] a, input logic [1:0] md, input logic [1:0] ex);
    logic wseen, dn, w, rq;
    int n, waited;
    wseen = 1'b0; dn = 1'b0; waited = 0; w = (md == 2'h3);
    @(posedge mclk_in);
    req_in <= 1'b1; leaf_in <= g_leaf; target_address_reg_in <= a;
    write_data_reg_in <= g_data; {long_mode_active_in, cs_long_in} <= md;
    current_privilege_level_in <= g_cpl; {ds_usable_in, ds_writable_in} <= g_ds;
    ds_limit_in <= g_lim; arith_flags_in <= g_data[31:0] ^ 32'h5a5a_0f0f;
    {map_in_epc_in, map_busy_in, map_valid_in, map_debug_in} <= g_map;
    map_type_in <= g_type;
    @(posedge mclk_in);
    req_in <= 1'b0;
    // lookup answered after g_dly idle cycles, to cover slow map replies
    for (n = 0; n < 14 && !dn; n++) begin
      @(negedge mclk_in);
      if (mem_wr_out === 1'b1) begin
        wseen = 1'b1;
        chk(mem_addr_out, a);
        chk(mem_be_out, w ? BE_WIDE : BE_NARROW);
        chk(mem_data_out & {{32{w}}, 32'hffff_ffff}, w ? g_data : g_data[31:0]);
      end
      dn = (done_out === 1'b1);
      rq = (map_req_out === 1'b1);
      if (!dn) begin
        @(posedge mclk_in);
        map_ack_in <= rq && (waited == g_dly);
        if (rq) waited++;
      end
    end
    chk(dn, ex != 2'h3);
    chk(wseen, ex == 2'h0);
    if (dn) begin
      chk({general_protection_fault_out, page_fault_exception_out}, {ex == 2'h1, ex == 2'h2});
      chk(fault_code_out, (ex == 2'h2) ? a : GP_ERR_CODE);
      chk(arith_flags_out, g_data[31:0] ^ 32'h5a5a_0f0f);
    end
  endtask

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk_in);
    rstn_in <= 1'b1;
    reg_rd(REG_CTRL, CTRL_RST);
    reg_rd(REG_STATUS, 32'h0);
    reg_rd(REG_MASK, 32'h0);
    reg_rd(8'hfc, 32'h0); // unmapped reads as zero
    op(64'h1000, 2'h3, 2'h0);
    g_dly = 5;
    op(64'h1234_5678, 2'h2, 2'h0);
    op(64'h1230, 2'h1, 2'h0);
    g_dly = 0;
    op(64'h1004, 2'h3, 2'h1);
    op(64'h1002, 2'h0, 2'h1);
    op(64'h1004, 2'h0, 2'h0);
    g_map = 4'b0011;
    op(64'h1000, 2'h3, 2'h2);
    g_map = 4'b1111;
    op(64'h1000, 2'h3, 2'h1);
    g_map = 4'b1001;
    op(64'h1000, 2'h3, 2'h2);
    g_map = 4'b1011;
    // three other page types (00, 03 and ff), control-structure pages among them
    foreach (g_data[i]) if (i < 3) begin
      g_type = (i == 0) ? 8'h00 : (i == 1) ? 8'h03 : 8'hff;
      op(64'h1000, 2'h3, 2'h2);
    end
    g_type = THREAD_PAGE_TYPE;
    op(64'h3008, 2'h3, 2'h0);
    op(64'h300c, 2'h0, 2'h0);
    op(64'h3010, 2'h3, 2'h1);
    g_type = REGULAR_PAGE_TYPE;
    g_map = 4'b1010;
    op(64'h1000, 2'h3, 2'h1);
    g_map = 4'b1011;
    g_cpl = 2'h3;
    op(64'h1000, 2'h3, 2'h1);
    g_cpl = 2'h1;
    op(64'h1000, 2'h0, 2'h1);
    g_cpl = 2'h0;
    g_ds = 2'h1;
    op(64'h1000, 2'h3, 2'h1);
    g_ds = 2'h2;
    op(64'h1000, 2'h0, 2'h1);
    g_ds = 2'h3; g_lim = 32'h0000_0fff;
    op(64'h2000, 2'h0, 2'h1);
    g_lim = 32'hffff_ffff;
    op(64'h0000_8000_0000_1000, 2'h3, 2'h1);
    op(64'hffff_8000_0000_1000, 2'h3, 2'h0);
    g_leaf = 32'h0000_0006;
    op(64'h1000, 2'h3, 2'h3);
    g_leaf = LEAF_DBG_WRITE;
    reg_rd(REG_STATUS, 32'hf);
    // sticky events, write-one-to-clear, masked level interrupt
    reg_wr(REG_STATUS, 32'hf);
    reg_rd(REG_STATUS, 32'h0);
    reg_wr(REG_MASK, 32'h2);
    op(64'h1004, 2'h3, 2'h1);
    repeat (2) @(negedge mclk_in);
    chk(irq_out, 1'b1);
    reg_rd(REG_STATUS, 32'h3);
    reg_wr(REG_STATUS, 32'h2);
    repeat (2) @(negedge mclk_in);
    chk(irq_out, 1'b0);
    reg_rd(REG_STATUS, 32'h1);
    // disabled block ignores requests silently
    reg_wr(REG_CTRL, 32'h0);
    op(64'h1000, 2'h3, 2'h3);
    reg_wr(REG_CTRL, 32'h1);
    op(64'h1008, 2'h3, 2'h0);
    end_sim();
  end

  // whole run is well under 2000 cycles; this cuts a hang short
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule // test_debug_enclave_write_check
